// ==== rtl/fkc_params.svh ====
// Offsets, key values, command codes and timing for the keyhole controller
`ifndef FKC_PARAMS_SVH
`define FKC_PARAMS_SVH

// Register byte offsets
`define FKC_OFS_KADDR 8'h00
`define FKC_OFS_DATL 8'h04
`define FKC_OFS_DATH 8'h08
`define FKC_OFS_KEY 8'h0C
`define FKC_OFS_CMD 8'h10
`define FKC_OFS_STAT 8'h14
`define FKC_OFS_EADDR 8'h18
`define FKC_OFS_SETUP 8'h1C

// Status and setup field positions
`define FKC_STA_BUSY 0
`define FKC_STA_DONE 2
`define FKC_STA_ERR 4
`define FKC_SET_DBG 0
`define FKC_SETUP_RST 1'b1

// Key words and command codes
`define FKC_KEY_FIRST 16'hF456
`define FKC_KEY_SECOND 16'hF123
`define FKC_CMD_PAGE 4'h1
`define FKC_CMD_WRITE 4'h4
`define FKC_CMD_MASS_DF 4'h6

// Memory map
`define FKC_DF_BASE 23'h400000
`define FKC_DF_SIZE 23'h001000
`define FKC_PF_PAGE_BITS 11
`define FKC_DF_PAGE_BITS 9

// Timing
`define FKC_CLK_NS 50
`define FKC_T_PROG_NS 20000
`define FKC_PROG_CYC ((`FKC_T_PROG_NS + `FKC_CLK_NS - 1) / `FKC_CLK_NS)
`define FKC_T_PERASE_US 2000
`define FKC_PERASE_CYC ((`FKC_T_PERASE_US * 1000) / `FKC_CLK_NS)
`define FKC_T_MERASE_US 4000
`define FKC_MERASE_CYC ((`FKC_T_MERASE_US * 1000) / `FKC_CLK_NS)

`endif

// ==== rtl/fkc_pkg.sv ====
// Types shared by the keyhole controller files
package fkc_pkg;
    typedef enum logic [1:0] {
        FKC_RG_NONE = 2'b00,
        FKC_RG_PF = 2'b01,
        FKC_RG_DF = 2'b10
    } fkc_region_t;

    typedef enum logic [1:0] {
        FKC_OP_IDLE = 2'b00,
        FKC_OP_PROG = 2'b01,
        FKC_OP_PAGE = 2'b10,
        FKC_OP_MASS = 2'b11
    } fkc_op_t;

    typedef enum logic [1:0] {
        FKC_KEY_IDLE = 2'b00,
        FKC_KEY_HALF = 2'b01,
        FKC_KEY_OPEN = 2'b10
    } fkc_key_t;
endpackage

// ==== rtl/fkc_op_timer.sv ====
// Countdown timer that paces one flash program or erase operation
`timescale 1ns/100ps
module fkc_op_timer #(
    parameter int CW = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [CW-1:0] load,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt_r;

    generate
        if (CW < 2) begin : g_bad_cw
            $error("fkc_op_timer: CW must be at least 2");
        end
    endgenerate

    assign busy = (cnt_r != '0);
    assign done = (cnt_r == CW'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= load;
        end else if (busy) begin
            cnt_r <= cnt_r - CW'(1);
        end
    end

    a_done_once: assert property (@(posedge clk) disable iff (!rst_n)
        done |=> !done) else $error("timer done lasted two cycles");
endmodule

// ==== rtl/fkc_keyhole.sv ====
// Flash keyhole controller: key, command sequencing, status, debug gate
`timescale 1ns/100ps
`include "fkc_params.svh"
module fkc_keyhole import fkc_pkg::*; #(
    parameter logic [22:0] PF_SIZE = 23'h020000,
    parameter int PERASE_CYC = `FKC_PERASE_CYC,
    parameter int MERASE_CYC = `FKC_MERASE_CYC,
    parameter int CW = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [22:0] keyhole_target_address,
    output logic [63:0] flash_wdata,
    output logic [1:0] pf_op,
    output logic [1:0] df_op,
    input wire logic df_read_req,
    output logic df_read_stall,
    input wire logic kernel_running,
    input wire logic swd_restrict_key,
    output logic swd_enable
);
    localparam int PROG_CYC = `FKC_PROG_CYC;
    generate
        if (PROG_CYC < 8 || PERASE_CYC < 8 || MERASE_CYC < 8 ||
            MERASE_CYC >= (1 << CW) || PERASE_CYC >= (1 << CW)) begin : g_bad
            $error("fkc_keyhole: operation counts do not fit the timer");
        end
        if (PF_SIZE[10:0] != 11'h000 || PF_SIZE > `FKC_DF_BASE) begin : g_pf
            $error("fkc_keyhole: PF_SIZE must be whole pages below data");
        end
    endgenerate
    // Region of a 23-bit memory mapped address
    function automatic fkc_region_t region_of(input logic [22:0] a);
        if (a < PF_SIZE) begin
            return FKC_RG_PF;
        end else if (a >= `FKC_DF_BASE &&
                     a < `FKC_DF_BASE + `FKC_DF_SIZE) begin
            return FKC_RG_DF;
        end
        return FKC_RG_NONE;
    endfunction
    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction
    // Bus slave state
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    // Keyhole registers and status
    logic [22:0] kaddr_r, eaddr_r, tgt_r;
    logic [31:0] datl_r, dath_r;
    logic [63:0] wdat_r;
    fkc_key_t key_r, key_nxt;
    fkc_op_t op_r;
    fkc_region_t op_rg_r;
    logic done_r, err_r, dbg_en_r, swd_r;
    logic [1:0] sync_a_r, sync_b_r;
    // Write decode
    wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    wire [7:0] wa = awaddr_r;
    wire wr_kaddr = wr_fire && wa == `FKC_OFS_KADDR;
    wire wr_datl = wr_fire && wa == `FKC_OFS_DATL;
    wire wr_dath = wr_fire && wa == `FKC_OFS_DATH;
    wire wr_key = wr_fire && wa == `FKC_OFS_KEY;
    wire wr_cmd = wr_fire && wa == `FKC_OFS_CMD;
    wire wr_stat = wr_fire && wa == `FKC_OFS_STAT;
    wire wr_eaddr = wr_fire && wa == `FKC_OFS_EADDR;
    wire wr_setup = wr_fire && wa == `FKC_OFS_SETUP;
    wire wr_map = wr_kaddr || wr_datl || wr_dath || wr_key || wr_cmd ||
                  wr_stat || wr_eaddr || wr_setup;
    wire [31:0] wnew = merge(32'h0000_0000, wdata_r, wstrb_r);
    // Command decode
    wire key_open = (key_r == FKC_KEY_OPEN);
    wire busy = (op_r != FKC_OP_IDLE);
    wire [3:0] code = wnew[3:0];
    wire fkc_region_t rg_w = region_of(kaddr_r);
    wire fkc_region_t rg_e = region_of(eaddr_r);
    wire is_write = (code == `FKC_CMD_WRITE);
    wire is_page = (code == `FKC_CMD_PAGE);
    wire is_mass = (code == `FKC_CMD_MASS_DF);
    wire fkc_region_t rg_sel = is_write ? rg_w :
                               is_page ? rg_e :
                               is_mass ? FKC_RG_DF : FKC_RG_NONE;
    wire cmd_ok = wr_cmd && key_open && !busy;
    wire start = cmd_ok && rg_sel != FKC_RG_NONE;
    wire err_set = (wr_cmd && !key_open) || (cmd_ok && !start);
    wire fkc_op_t op_sel = is_write ? FKC_OP_PROG :
                           is_page ? FKC_OP_PAGE : FKC_OP_MASS;
    wire [CW-1:0] load = is_write ? CW'(PROG_CYC) :
                         is_page ? CW'(PERASE_CYC) : CW'(MERASE_CYC);
    // Page base address for page erase
    wire [22:0] page_base = (rg_e == FKC_RG_PF) ?
        {eaddr_r[22:`FKC_PF_PAGE_BITS], {`FKC_PF_PAGE_BITS{1'b0}}} :
        {eaddr_r[22:`FKC_DF_PAGE_BITS], {`FKC_DF_PAGE_BITS{1'b0}}};
    wire [22:0] tgt_sel = is_write ? {kaddr_r[22:3], 3'b000} :
                          is_page ? page_base : `FKC_DF_BASE;
    logic tmr_busy, tmr_done;
    fkc_op_timer #(.CW(CW)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(start),
        .load(load),
        .busy(tmr_busy),
        .done(tmr_done)
    );
    // AXI4-Lite write channels
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? 2'b00 : 2'b10;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channels
    wire [31:0] stat_word = {27'h0, err_r, 1'b0, done_r, 1'b0, busy};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire rd_map = ra <= `FKC_OFS_SETUP;
    wire [31:0] rd_mux =
        (ra == `FKC_OFS_KADDR) ? {9'h000, kaddr_r} :
        (ra == `FKC_OFS_DATL) ? datl_r :
        (ra == `FKC_OFS_DATH) ? dath_r :
        (ra == `FKC_OFS_STAT) ? stat_word :
        (ra == `FKC_OFS_EADDR) ? {9'h000, eaddr_r} :
        (ra == `FKC_OFS_SETUP) ? {31'h0, dbg_en_r} : 32'h0000_0000;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_map ? 2'b00 : 2'b10;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    // Key sequence
    always_comb begin
        key_nxt = key_r;
        if (wr_cmd) begin
            key_nxt = FKC_KEY_IDLE;
        end else if (wr_key) begin
            case (key_r)
                FKC_KEY_HALF: begin
                    key_nxt = (wnew[15:0] == `FKC_KEY_SECOND) ?
                              FKC_KEY_OPEN : FKC_KEY_IDLE;
                end
                default: begin
                    key_nxt = (wnew[15:0] == `FKC_KEY_FIRST) ?
                              FKC_KEY_HALF : FKC_KEY_IDLE;
                end
            endcase
        end
    end
    // Software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_r <= FKC_KEY_IDLE;
            kaddr_r <= 23'h000000;
            eaddr_r <= 23'h000000;
            datl_r <= 32'h0000_0000;
            dath_r <= 32'h0000_0000;
            dbg_en_r <= `FKC_SETUP_RST;
        end else begin
            key_r <= key_nxt;
            if (wr_kaddr) begin
                kaddr_r <= 23'(merge({9'h000, kaddr_r}, wdata_r, wstrb_r));
            end
            if (wr_eaddr) begin
                eaddr_r <= 23'(merge({9'h000, eaddr_r}, wdata_r, wstrb_r));
            end
            if (wr_datl) begin
                datl_r <= merge(datl_r, wdata_r, wstrb_r);
            end
            if (wr_dath) begin
                dath_r <= merge(dath_r, wdata_r, wstrb_r);
            end
            if (wr_setup && key_open && wstrb_r[0]) begin
                dbg_en_r <= wdata_r[`FKC_SET_DBG];
            end
        end
    end
    // Operation and status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= FKC_OP_IDLE;
            op_rg_r <= FKC_RG_NONE;
            tgt_r <= 23'h000000;
            wdat_r <= 64'h0000_0000_0000_0000;
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            if (start) begin
                op_r <= op_sel;
                op_rg_r <= rg_sel;
                tgt_r <= tgt_sel;
                wdat_r <= {dath_r, datl_r};
            end else if (tmr_done) begin
                op_r <= FKC_OP_IDLE;
                op_rg_r <= FKC_RG_NONE;
            end
            if (tmr_done) begin
                done_r <= 1'b1;
            end else if (start || (wr_stat && wnew[`FKC_STA_DONE])) begin
                done_r <= 1'b0;
            end
            if (err_set) begin
                err_r <= 1'b1;
            end else if (wr_stat && wnew[`FKC_STA_ERR]) begin
                err_r <= 1'b0;
            end
        end
    end
    assign keyhole_target_address = tgt_r;
    assign flash_wdata = wdat_r;
    assign pf_op = (op_rg_r == FKC_RG_PF) ? op_r : FKC_OP_IDLE;
    assign df_op = (op_rg_r == FKC_RG_DF) ? op_r : FKC_OP_IDLE;
    // Program array operations hold off data array reads
    assign df_read_stall = df_read_req && op_rg_r == FKC_RG_PF;
    // Pin synchronisers for kernel and restriction key
    wire [1:0] pin_in = {swd_restrict_key, kernel_running};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_a_r[gi] <= 1'b1;
                    sync_b_r[gi] <= 1'b1;
                end else begin
                    sync_a_r[gi] <= pin_in[gi];
                    sync_b_r[gi] <= sync_a_r[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swd_r <= 1'b0;
        end else begin
            swd_r <= dbg_en_r && !sync_b_r[0] && !sync_b_r[1];
        end
    end
    assign swd_enable = swd_r;
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_key_second;
        wr_key && key_r == FKC_KEY_HALF && wnew[15:0] == `FKC_KEY_SECOND;
    endsequence
    sequence s_op_start;
        start && is_write;
    endsequence

    a_key_open: assert property (s_key_second |=> key_open)
        else $error("key did not open after second word");
    a_key_cmd_clear: assert property (wr_cmd |=> !key_open)
        else $error("key still open after command write");
    a_key_bad_word: assert property (wr_key && !wr_cmd &&
        wnew[15:0] != `FKC_KEY_FIRST && wnew[15:0] != `FKC_KEY_SECOND
        |=> key_r == FKC_KEY_IDLE) else $error("bad key word kept key");
    a_refuse_nokey: assert property (wr_cmd && !key_open
        |=> ($stable(op_r) || op_r == FKC_OP_IDLE) && err_r)
        else $error("command without key ran");
    a_prog_data: assert property (s_op_start |=>
        flash_wdata == {$past(dath_r), $past(datl_r)} && op_r == FKC_OP_PROG)
        else $error("program data not taken from data registers");
    a_busy_run: assert property (start |=> busy [*8])
        else $error("busy dropped early");
    a_done_end: assert property (tmr_done |=> !busy && done_r)
        else $error("done flag not set at completion");
    a_bad_region: assert property (cmd_ok && rg_sel == FKC_RG_NONE
        |=> err_r && !busy) else $error("bad region not flagged");
    a_page_align: assert property (start && is_page && rg_e == FKC_RG_PF
        |=> tgt_r[10:0] == 11'h000 && pf_op == FKC_OP_PAGE)
        else $error("program page erase not page aligned");
    a_df_stall: assert property (df_read_req && pf_op != FKC_OP_IDLE
        |-> df_read_stall) else $error("data read not stalled");
    a_swd_kernel: assert property (sync_b_r[0] |=> !swd_enable)
        else $error("serial wire open while kernel runs");
    a_dbg_off: assert property (!dbg_en_r |=> !swd_enable)
        else $error("serial wire open with debug disabled");
    a_timer_busy: assert property (busy == tmr_busy)
        else $error("status busy and timer disagree");
endmodule

// ==== bench/fkc_flash_model.sv ====
// Behavioural model of the program and data flash arrays
`timescale 1ns/100ps
`include "fkc_params.svh"
module fkc_flash_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] pf_op,
    input wire logic [1:0] df_op,
    input wire logic [22:0] keyhole_target_address,
    input wire logic [63:0] flash_wdata,
    input wire logic rd_en,
    input wire logic df_read_stall,
    output logic df_read_req,
    output int op_cnt,
    output int reprog_cnt,
    output int clash_cnt,
    output logic [63:0] last_data
);
    logic [63:0] mem [logic [22:0]];
    logic [1:0] pf_q;
    logic [1:0] df_q;
    logic [1:0] op;
    logic [22:0] a;
    int n;
    int i;

    // Core read of the data array; held as a level while stalled
    assign df_read_req = rd_en;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_q = 2'b00;
            df_q = 2'b00;
            op_cnt = 0;
            reprog_cnt = 0;
            clash_cnt = 0;
            last_data = 64'h0;
        end else begin
            // Data read let through under a program array operation
            if (df_read_req && !df_read_stall && pf_op != 2'b00) begin
                clash_cnt++;
            end
            op = pf_op | df_op;
            a = keyhole_target_address;
            if ((pf_op != 2'b00 && pf_q == 2'b00) ||
                (df_op != 2'b00 && df_q == 2'b00)) begin
                op_cnt++;
                if (op == 2'b01) begin
                    // Second program without an erase is a misuse
                    if (mem.exists(a)) reprog_cnt++;
                    mem[a] = flash_wdata;
                    last_data = flash_wdata;
                end else begin
                    n = (op == 2'b11) ? 4096 :
                        ((a >= `FKC_DF_BASE) ? 512 : 2048);
                    for (i = 0; i < n; i += 8) begin
                        mem.delete(a + 23'(i));
                    end
                end
            end
            pf_q = pf_op;
            df_q = df_op;
        end
    end
endmodule

// ==== bench/flash_keyhole_controller_test.sv ====
// Self-checking bench for the flash keyhole controller
`timescale 1ns/100ps
`include "fkc_params.svh"
module flash_keyhole_controller_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic kern = 1'b0;
    logic rkey = 1'b0;
    logic rd_en = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, stall, swd, df_req;
    logic [1:0] bresp, rresp, pf_op, df_op, resp;
    logic [31:0] rdata, rd;
    logic [22:0] tgt;
    logic [63:0] fwd, mdata;
    int op_cnt, reprog_cnt, clash_cnt;
    int num_errors = 0;
    int n_checks = 0;

    always #25 clk = ~clk;

    fkc_keyhole #(.PERASE_CYC(20), .MERASE_CYC(30)) u_dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .keyhole_target_address(tgt), .flash_wdata(fwd),
        .pf_op(pf_op), .df_op(df_op), .df_read_req(df_req),
        .df_read_stall(stall), .kernel_running(kern),
        .swd_restrict_key(rkey), .swd_enable(swd)
    );

    fkc_flash_model u_flash (
        .clk(clk), .rst_n(rst_n), .pf_op(pf_op), .df_op(df_op),
        .keyhole_target_address(tgt), .flash_wdata(fwd), .rd_en(rd_en),
        .df_read_stall(stall), .df_read_req(df_req), .op_cnt(op_cnt),
        .reprog_cnt(reprog_cnt), .clash_cnt(clash_cnt),
        .last_data(mdata)
    );

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        if (i == 100) check("write answer", 1'b1, 1'b0);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        int i;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata;
        resp = rresp;
        if (i == 100) check("read answer", 1'b1, 1'b0);
        rready <= 1'b0;
    endtask

    task automatic key();
        wr(`FKC_OFS_KEY, 32'h0000F456);
        wr(`FKC_OFS_KEY, 32'h0000F123);
    endtask

    task automatic clr();
        wr(`FKC_OFS_STAT, 32'h00000014);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 1000; i++) begin
            rdr(`FKC_OFS_STAT);
            if (rd[0] === 1'b0) break;
        end
    endtask

    // Full command: address, data, key, command, then poll to completion
    task automatic run(input logic [3:0] c, input logic [7:0] ar,
                       input logic [22:0] a, input logic [63:0] d,
                       input logic [1:0] pe, input logic [1:0] de,
                       input logic [22:0] te);
        clr();
        wr(ar, {9'h0, a});
        wr(`FKC_OFS_DATL, d[31:0]);
        wr(`FKC_OFS_DATH, d[63:32]);
        key();
        wr(`FKC_OFS_CMD, {28'h0, c});
        #1;
        check("pf_op", pe, pf_op);
        check("df_op", de, df_op);
        check("target", te, tgt);
        check("stall busy", pe != 2'b00, stall);
        if (c == 4'h4) check("wdata", d, fwd);
        rdr(`FKC_OFS_STAT);
        check("busy", 32'h1, rd);
        wait_idle();
        check("done", 32'h4, rd);
        #1;
        check("ops idle", 4'h0, {pf_op, df_op});
        check("stall idle", 1'b0, stall);
    endtask

    task automatic refused();
        wr(`FKC_OFS_CMD, 32'h4);
        #1;
        check("no op", 4'h0, {pf_op, df_op});
        rdr(`FKC_OFS_STAT);
        check("error", 32'h10, rd);
        clr();
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #(50 * 60000);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_en <= 1'b1;
        rdr(`FKC_OFS_STAT);
        check("status rst", 32'h0, rd);
        rdr(`FKC_OFS_SETUP);
        check("setup rst", 32'h1, rd);
        check("swd rst", 1'b1, swd);
        wr(8'h20, 32'h1);
        check("bresp", 2'b10, resp);
        rdr(8'h20);
        check("rresp", 2'b10, resp);
        wr(`FKC_OFS_KADDR, 32'hFFFFFFFF);
        rdr(`FKC_OFS_KADDR);
        check("address", 32'h007FFFFF, rd);
        rdr(`FKC_OFS_KEY);
        check("key read", 32'h0, rd);
        run(4'h4, `FKC_OFS_KADDR, 23'h001800, 64'h89ABCDEF01234567,
            2'b01, 2'b00, 23'h001800);
        check("array data", 64'h89ABCDEF01234567, mdata);
        run(4'h4, `FKC_OFS_KADDR, 23'h400008, 64'h0000FFFF5555AAAA,
            2'b00, 2'b01, 23'h400008);
        run(4'h4, `FKC_OFS_KADDR, 23'h01FFF8, 64'h0123456700000000,
            2'b01, 2'b00, 23'h01FFF8);
        run(4'h1, `FKC_OFS_EADDR, 23'h010010, 64'h0,
            2'b10, 2'b00, 23'h010000);
        run(4'h1, `FKC_OFS_EADDR, 23'h400234, 64'h0,
            2'b00, 2'b10, 23'h400200);
        run(4'h6, `FKC_OFS_EADDR, 23'h0, 64'h0,
            2'b00, 2'b11, 23'h400000);
        clr();
        refused();
        wr(`FKC_OFS_KADDR, 32'h00020000);
        key();
        refused();
        wr(`FKC_OFS_KADDR, 32'h00401000);
        key();
        refused();
        wr(`FKC_OFS_KADDR, 32'h00001808);
        key();
        wr(`FKC_OFS_KEY, 32'h0);
        refused();
        wr(`FKC_OFS_KEY, 32'h0000F123);
        wr(`FKC_OFS_KEY, 32'h0000F456);
        refused();
        wr(`FKC_OFS_KADDR, 32'h00001810);
        key();
        wr(`FKC_OFS_CMD, 32'h4);
        wait_idle();
        clr();
        refused();
        check("ops done", 7, op_cnt);
        check("reprogram", 0, reprog_cnt);
        check("read clash", 0, clash_cnt);
        wr(`FKC_OFS_SETUP, 32'h0);
        rdr(`FKC_OFS_SETUP);
        check("setup locked", 32'h1, rd);
        key();
        wr(`FKC_OFS_SETUP, 32'h0);
        rdr(`FKC_OFS_SETUP);
        check("setup dbg", 32'h0, rd);
        check("swd off", 1'b0, swd);
        key();
        wr(`FKC_OFS_SETUP, 32'h1);
        repeat (5) @(posedge clk);
        check("swd on", 1'b1, swd);
        kern <= 1'b1;
        repeat (5) @(posedge clk);
        check("swd kernel", 1'b0, swd);
        kern <= 1'b0;
        rkey <= 1'b1;
        repeat (5) @(posedge clk);
        check("swd restrict", 1'b0, swd);
        rkey <= 1'b0;
        repeat (5) @(posedge clk);
        check("swd back", 1'b1, swd);
        close_out();
    end
endmodule
